// [lec_map.vh]
// Register map and field layout for lane 6/7 error counter control.
// Assumes an 8-bit register access path with a 15-bit address.
// Notes on behaviour
// - Lane 6 enables in bits 5:3, reset 0x7
// - Lane 6 counter resets bits 2:0, reset 0x7
// - Lane 7 enables in bits 5:3, reset 0x7
// - Lane 7 counter resets bits 2:0, reset 0x7
// - Bit2 control char, bit1 table, bit0 disparity
// - Counter rolls over unless hold keeps 0xFF
`ifndef LEC_MAP_VH
`define LEC_MAP_VH
`define LEC_ADDR_LANE6 15'h0486
`define LEC_ADDR_LANE7 15'h0487
`define LEC_ENA_HI 5
`define LEC_ENA_LO 3
`define LEC_RST_HI 2
`define LEC_RST_LO 0
`define LEC_ENA_RESET 3'h7
`define LEC_RST_RESET 3'h7
`define LEC_BIT_CTRL_CHAR 2
`define LEC_BIT_NOT_IN_TABLE 1
`define LEC_BIT_DISPARITY 0
`define LEC_CNT_TERMINAL 8'hFF
`endif

// [lec_counter.v]
// One 8-bit error counter with enable, clear and terminal-count hold.
// Assumes error pulses are synchronous to mclk_i.
`include "lec_map.vh"
module lec_counter #(
  parameter WIDTH = 8
) (
  input wire mclk_i,
  input wire rst_i,
  input wire enable_i,
  input wire clear_i,
  input wire hold_i,
  input wire error_i,
  output reg [WIDTH-1:0] count_o
);
  always @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (enable_i && error_i) begin
      // Hold at all ones only when asked; otherwise natural wrap
      if (!(hold_i && (&count_o))) begin
        count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [lec_ctrl.v]
// Control registers and error counters for receive lanes 6 and 7.
// Assumes a synchronous byte register port decoded upstream; error pulses on mclk_i.
`include "lec_map.vh"
module lec_ctrl #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Register port
  input wire [14:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Error events, bit order control char, table, disparity
  input wire [2:0] lane6_error_i,
  input wire [2:0] lane7_error_i,
  // Terminal-count hold from neighbouring registers
  input wire [2:0] lane6_hold_i,
  input wire [2:0] lane7_hold_i,
  // Counter values, lane 6 then lane 7, lowest bit index first
  output wire [6*WIDTH-1:0] counts_o
);
  reg [2:0] lane6_counter_enables_reg;
  reg [2:0] lane6_counter_resets_reg;
  reg [2:0] lane7_counter_enables_reg;
  reg [2:0] lane7_counter_resets_reg;
  wire [5:0] ena_all;
  wire [5:0] rst_all;
  wire [5:0] hold_all;
  wire [5:0] err_all;
  reg [7:0] rdata_next;

  function is_addr;
    input [14:0] a;
    input [14:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  always @(posedge mclk_i) begin
    if (rst_i) begin
      lane6_counter_enables_reg <= `LEC_ENA_RESET;
      lane6_counter_resets_reg <= `LEC_RST_RESET;
      lane7_counter_enables_reg <= `LEC_ENA_RESET;
      lane7_counter_resets_reg <= `LEC_RST_RESET;
    end else if (reg_wr_i) begin
      if (is_addr(reg_addr_i, `LEC_ADDR_LANE6)) begin
        lane6_counter_enables_reg <= reg_wdata_i[`LEC_ENA_HI:`LEC_ENA_LO];
        lane6_counter_resets_reg <= reg_wdata_i[`LEC_RST_HI:`LEC_RST_LO];
      end
      if (is_addr(reg_addr_i, `LEC_ADDR_LANE7)) begin
        lane7_counter_enables_reg <= reg_wdata_i[`LEC_ENA_HI:`LEC_ENA_LO];
        lane7_counter_resets_reg <= reg_wdata_i[`LEC_RST_HI:`LEC_RST_LO];
      end
    end
  end

  // Reserved bits 7:6 read zero; unmapped addresses read zero
  always @* begin
    rdata_next = 8'h00;
    if (is_addr(reg_addr_i, `LEC_ADDR_LANE6)) begin
      rdata_next = {2'h0, lane6_counter_enables_reg, lane6_counter_resets_reg};
    end else if (is_addr(reg_addr_i, `LEC_ADDR_LANE7)) begin
      rdata_next = {2'h0, lane7_counter_enables_reg, lane7_counter_resets_reg};
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // Index i: lane 6 at 0..2, lane 7 at 3..5; bit within lane per map
  assign ena_all = {lane7_counter_enables_reg, lane6_counter_enables_reg};
  assign rst_all = {lane7_counter_resets_reg, lane6_counter_resets_reg};
  assign hold_all = {lane7_hold_i, lane6_hold_i};
  assign err_all = {lane7_error_i, lane6_error_i};

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_cnt
      lec_counter #(
        .WIDTH(WIDTH)
      ) u_cnt (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(ena_all[i]),
        .clear_i(rst_all[i]),
        .hold_i(hold_all[i]),
        .error_i(err_all[i]),
        .count_o(counts_o[i*WIDTH +: WIDTH])
      );
    end
  endgenerate
endmodule

// [lec_ctrl_assertions.sv]
// Port checker for lec_ctrl.
// Assumes one clock and a sync reset.
module lec_chk #(parameter WIDTH = 8) (
  input logic mclk_i, rst_i, reg_wr_i,
  input logic [14:0] reg_addr_i,
  input logic [7:0] reg_wdata_i, reg_rdata_o,
  input logic [2:0] lane6_error_i, lane7_error_i, lane6_hold_i, lane7_hold_i,
  input logic [6*WIDTH-1:0] counts_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  cnt_clear_a: assert property ($fell(rst_i) |-> counts_o == 0) else $error("cnt");
  reg_init_a: assert property ($fell(rst_i) && reg_addr_i[14:1] == 14'h0243
    |=> reg_rdata_o == 8'h3F) else $error("init");
  lane6_wr_a: assert property (reg_wr_i && reg_addr_i == 15'h0486
    ##1 reg_addr_i == 15'h0486 |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
    else $error("wr6");
  lane7_wr_a: assert property (reg_wr_i && reg_addr_i == 15'h0487
    ##1 reg_addr_i == 15'h0487 |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
    else $error("wr7");
  lane6_map_a: assert property (lane6_error_i == 3'h1 |=>
    $stable(counts_o[15:8]) || counts_o[15:8] == 0) else $error("map");
  lane7_idle_a: assert property (!lane7_error_i[0] |=>
    $stable(counts_o[31:24]) || counts_o[31:24] == 0) else $error("idle");
  lane6_hold_a: assert property (counts_o[7:0] == 8'hFF && lane6_hold_i[0] |=>
    counts_o[7:0] inside {8'hFF, 8'h00}) else $error("hold");
  cover property (lane6_error_i[0] ##1 counts_o[7:0] == 8'h01);
  cover property (counts_o[7:0] == 8'hFF && lane6_hold_i[0]);
  cover property (reg_wr_i && reg_addr_i == 15'h0487);
endmodule
bind lec_ctrl lec_chk #(.WIDTH(WIDTH)) i_lec_chk (.*);

// [lec_ctrl_bench.sv]
// Self-checking bench for lec_ctrl.
// Drives all ports directly; no far-side model.
module lec_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_i = 1, reg_wr_i = 0;
  logic [14:0] reg_addr_i = 15'h0486;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [2:0] e6 = 3'h0, e7 = 3'h0, h6 = 3'h0, h7 = 3'h0;
  logic [47:0] counts_o;
  int mismatches = 0, checks = 0;
  lec_ctrl i_lec_ctrl (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .lane6_error_i(e6), .lane7_error_i(e7), .lane6_hold_i(h6), .lane7_hold_i(h7), .counts_o);
  initial forever #5 mclk_i = ~mclk_i;
  task cy(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task chk(string n, logic [47:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [14:0] a, logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    cy(1);
    reg_wr_i = 0;
    // Idle edge so a following write never re-raises the strobe in one step
    cy(1);
  endtask
  task rd(logic [14:0] a, logic [7:0] e);
    reg_addr_i = a;
    cy(2);
    chk("rdata", {40'h0, e}, {40'h0, reg_rdata_o});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reserved bits and an unmapped address must read back zero
  task t_regs;
    rd(15'h0486, 8'h3F);
    rd(15'h0487, 8'h3F);
    wr(15'h0486, 8'hF8);
    wr(15'h0488, 8'hFF);
    wr(15'h0487, 8'h30);
    rd(15'h0486, 8'h38);
    rd(15'h0487, 8'h30);
    rd(15'h0488, 8'h00);
  endtask
  // One-cycle pulses; lane 7 disparity counter is disabled
  task t_count;
    e6 = 3'h1;
    e7 = 3'h7;
    cy(1);
    e6 = 3'h0;
    e7 = 3'h0;
    cy(1);
    chk("counts", 48'h010100000001, counts_o);
  endtask
  // 256 errors: held counter saturates, free one wraps to its start
  task t_hold;
    h6 = 3'h1;
    e6 = 3'h3;
    cy(256);
    e6 = 3'h0;
    chk("counts", 48'h0101000000FF, counts_o);
    wr(15'h0486, 8'h39);
    e6 = 3'h1;
    cy(3);
    chk("counts", 48'h010100000000, counts_o);
  endtask
  // Lane 7 control char counter held by its reset bit, others count
  task t_lane7;
    e6 = 3'h0;
    wr(15'h0487, 8'h3C);
    e7 = 3'h7;
    cy(1);
    e7 = 3'h0;
    chk("counts", 48'h000201000000, counts_o);
  endtask
  // Mid-run reset brings counters and both registers back
  task t_rst;
    rst_i = 1;
    cy(2);
    rst_i = 0;
    chk("counts", 48'h0, counts_o);
    rd(15'h0487, 8'h3F);
    rd(15'h0486, 8'h3F);
  endtask
  initial begin
    cy(5);
    rst_i = 0;
    chk("counts", 48'h0, counts_o);
    t_regs();
    t_count();
    t_hold();
    t_lane7();
    t_rst();
    close_out();
  end
endmodule
